// File: hw/ectmr_cfg.svh
// constants for the eight-bit counter/timer: offsets, fields, reset values
// How it works
// - control bit 7 starts or stops counter
// - bit 6 low: reload at terminal count
// - bit 6 high: stop at terminal count
// - terminal count sets timeout flag bit 5
// - writing one clears timeout; nothing else
// - bit 2 gates data-capture interrupt
// - bit 1 gates timeout interrupt
// - bit 0 routes counter output to pin
// - high-level count hold at offset 05H
// - low-level count hold at offset 04H
// - registers live in expanded bank 0Dh
// - first prescaled tick may be short
// - bits 4:3 pick clock divide 1/2/4/8
`ifndef ECTMR_CFG_SVH
`define ECTMR_CFG_SVH
// ==========================================================
// register map
`define ECTMR_BANK 4'hD
`define ECTMR_OFF_CONTROL 4'h0
`define ECTMR_OFF_LOW_HOLD 4'h4
`define ECTMR_OFF_HIGH_HOLD 4'h5
// ==========================================================
// control fields
`define ECTMR_BIT_RUN 7
`define ECTMR_BIT_SINGLE 6
`define ECTMR_BIT_TIMEOUT 5
`define ECTMR_BIT_CLK_HI 4
`define ECTMR_BIT_CLK_LO 3
`define ECTMR_BIT_CAP_MASK 2
`define ECTMR_BIT_TO_MASK 1
`define ECTMR_BIT_ROUTE 0
`define ECTMR_CONTROL_RST 8'h00
`define ECTMR_HOLD_RST 8'h00
`define ECTMR_COUNT_ONE 8'h01
`endif

// File: hw/ectmr_pkg.sv
// types shared by the eight-bit counter/timer
package ectmr_pkg;
    typedef enum logic [1:0] {
        ECTMR_DIV1 = 2'b00,
        ECTMR_DIV2 = 2'b01,
        ECTMR_DIV4 = 2'b10,
        ECTMR_DIV8 = 2'b11
    } ectmr_div_t;
    typedef enum logic [1:0] {
        ECTMR_IDLE = 2'b00,
        ECTMR_LOAD = 2'b01,
        ECTMR_COUNT = 2'b10
    } ectmr_state_t;
endpackage

// File: hw/ectmr_prescale.sv
// free-running prescaler producing a one-cycle tick at the selected rate
`timescale 1ns/1ps
`include "ectmr_cfg.svh"
module ectmr_prescale
    import ectmr_pkg::*;
#(
    parameter int DIV_WIDTH = 3
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [1:0] sel_in,
    output logic tick_out
);
    initial begin
        if (DIV_WIDTH < 3) begin
            $error("prescaler needs at least three bits");
        end
    end
    logic [DIV_WIDTH-1:0] div_r;
    // ==========================================================
    // divider: never cleared on enable, so the first tick can land early
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end
    always_comb begin
        unique case (ectmr_div_t'(sel_in))
            ECTMR_DIV1: tick_out = 1'b1;
            ECTMR_DIV2: tick_out = div_r[0];
            ECTMR_DIV4: tick_out = &div_r[1:0];
            ECTMR_DIV8: tick_out = &div_r[2:0];
        endcase
    end
endmodule

// File: hw/ectmr_top.sv
// eight-bit counter/timer with control and two hold registers
`timescale 1ns/1ps
`include "ectmr_cfg.svh"
module ectmr_top
    import ectmr_pkg::*;
#(
    parameter int COUNT_WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] bank_sel_in,
    input wire logic [3:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    input wire logic port_data_in,
    input wire logic capture_event_in,
    output logic counter_out_pin_out,
    output logic timeout_irq_out,
    output logic capture_irq_out,
    output logic [7:0] byte_counter_out
);
    initial begin
        if (COUNT_WIDTH != 8) begin
            $error("byte counter is eight bits wide");
        end
    end

    logic [7:0] timer8_control_r;
    logic [7:0] timer8_low_hold_r;
    logic [7:0] timer8_high_hold_r;
    logic [7:0] byte_counter_r;
    logic [7:0] byte_counter_nxt;
    logic out_level_r;
    logic use_high_r;
    logic timeout_irq_r;
    logic capture_irq_r;
    logic [7:0] rdata_r;
    ectmr_state_t state_r;
    ectmr_state_t state_nxt;
    logic tick;
    logic hit_tc;
    logic stop_pass;
    logic [7:0] reload_val;

    // ==========================================================
    // register decode
    function automatic logic sel(input logic [3:0] bank, input logic [3:0] a,
                                 input logic [3:0] off);
        sel = (bank == `ECTMR_BANK) && (a == off);
    endfunction

    wire logic wr_ctl = wr_in && sel(bank_sel_in, addr_in, `ECTMR_OFF_CONTROL);
    wire logic wr_lo = wr_in && sel(bank_sel_in, addr_in, `ECTMR_OFF_LOW_HOLD);
    wire logic wr_hi = wr_in && sel(bank_sel_in, addr_in, `ECTMR_OFF_HIGH_HOLD);
    wire logic run = timer8_control_r[`ECTMR_BIT_RUN];
    wire logic single = timer8_control_r[`ECTMR_BIT_SINGLE];
    wire logic route = timer8_control_r[`ECTMR_BIT_ROUTE];

    // ==========================================================
    // prescaler
    ectmr_prescale #(
        .DIV_WIDTH(3)
    ) u_prescale (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .sel_in(timer8_control_r[`ECTMR_BIT_CLK_HI:`ECTMR_BIT_CLK_LO]),
        .tick_out(tick)
    );

    // ==========================================================
    // counter control
    // terminal count is a tick at zero; a count of zero would expire on the first tick
    // a cleared run bit stops the count at once, so no late terminal count slips out
    assign hit_tc = run && (state_r == ECTMR_COUNT) && tick && (byte_counter_r == 8'h00);
    assign stop_pass = hit_tc && single;
    // start loads low; in routed mode each terminal count loads the other hold value
    assign reload_val = (route && !use_high_r && (state_r == ECTMR_COUNT))
                        ? timer8_high_hold_r : timer8_low_hold_r;

    always_comb begin
        state_nxt = state_r;
        byte_counter_nxt = byte_counter_r;
        unique case (state_r)
            ECTMR_IDLE: begin
                if (run) begin
                    state_nxt = ECTMR_LOAD;
                end
            end
            ECTMR_LOAD: begin
                // restart always reloads, so no stale count survives a stop
                byte_counter_nxt = reload_val;
                state_nxt = ECTMR_COUNT;
            end
            ECTMR_COUNT: begin
                if (tick) begin
                    if (byte_counter_r != 8'h00) begin
                        byte_counter_nxt = byte_counter_r - 8'h01;
                    end else if (!single) begin
                        byte_counter_nxt = reload_val;
                    end
                    // single pass parks at zero without reloading
                end
                if (stop_pass) begin
                    state_nxt = ECTMR_IDLE;
                end
            end
            default: state_nxt = ECTMR_IDLE;
        endcase
        if (!run) begin
            state_nxt = ECTMR_IDLE;
            byte_counter_nxt = byte_counter_r;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= ECTMR_IDLE;
            byte_counter_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            byte_counter_r <= byte_counter_nxt;
        end
    end

    // ==========================================================
    // output level and hold alternation
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            out_level_r <= 1'b0;
            use_high_r <= 1'b0;
        end else if (state_r == ECTMR_IDLE) begin
            use_high_r <= 1'b0;
        end else if (hit_tc && route) begin
            out_level_r <= ~out_level_r;
            use_high_r <= ~use_high_r;
        end
    end

    // ==========================================================
    // control register; the run bit drops after a single pass
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            timer8_control_r <= `ECTMR_CONTROL_RST;
        end else begin
            if (wr_ctl) begin
                timer8_control_r[7:6] <= wdata_in[7:6];
                timer8_control_r[4:0] <= wdata_in[4:0];
            end
            if (stop_pass && !(wr_ctl && wdata_in[`ECTMR_BIT_RUN])) begin
                timer8_control_r[`ECTMR_BIT_RUN] <= 1'b0;
            end
            // set beats a simultaneous write-one clear
            if (hit_tc) begin
                timer8_control_r[`ECTMR_BIT_TIMEOUT] <= 1'b1;
            end else if (wr_ctl && wdata_in[`ECTMR_BIT_TIMEOUT]) begin
                timer8_control_r[`ECTMR_BIT_TIMEOUT] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // hold registers
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            timer8_low_hold_r <= `ECTMR_HOLD_RST;
            timer8_high_hold_r <= `ECTMR_HOLD_RST;
        end else begin
            if (wr_lo) begin
                timer8_low_hold_r <= wdata_in;
            end
            if (wr_hi) begin
                timer8_high_hold_r <= wdata_in;
            end
        end
    end

    // ==========================================================
    // interrupt request pulses, gated by the control masks
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            timeout_irq_r <= 1'b0;
            capture_irq_r <= 1'b0;
        end else begin
            timeout_irq_r <= hit_tc && timer8_control_r[`ECTMR_BIT_TO_MASK];
            capture_irq_r <= capture_event_in
                             && timer8_control_r[`ECTMR_BIT_CAP_MASK];
        end
    end

    // ==========================================================
    // read port, registered
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_r <= 8'h00;
        end else if (rd_in) begin
            if (sel(bank_sel_in, addr_in, `ECTMR_OFF_CONTROL)) begin
                rdata_r <= timer8_control_r;
            end else if (sel(bank_sel_in, addr_in, `ECTMR_OFF_LOW_HOLD)) begin
                rdata_r <= timer8_low_hold_r;
            end else if (sel(bank_sel_in, addr_in, `ECTMR_OFF_HIGH_HOLD)) begin
                rdata_r <= timer8_high_hold_r;
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign rdata_out = rdata_r;
    assign timeout_irq_out = timeout_irq_r;
    assign capture_irq_out = capture_irq_r;
    assign byte_counter_out = byte_counter_r;
    // pin mux is combinational; the routed level is registered, port data passes straight through
    assign counter_out_pin_out = route ? out_level_r : port_data_in;
endmodule

// File: tb/ectmr_asserts.sv
// port-level assertion checker for the eight-bit counter/timer
`timescale 1ns/1ps
`include "ectmr_cfg.svh"
module ectmr_asserts
    import ectmr_pkg::*;
#(
    parameter int COUNT_WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] bank_sel_in,
    input wire logic [3:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] rdata_out,
    input wire logic port_data_in,
    input wire logic capture_event_in,
    input wire logic counter_out_pin_out,
    input wire logic timeout_irq_out,
    input wire logic capture_irq_out,
    input wire logic [7:0] byte_counter_out
);
    // ==========================================
    // shadows of software-written fields
    logic [7:0] ctl_r;
    logic [7:0] low_r;
    logic [7:0] high_r;
    logic hit;
    logic rsel;
    assign hit = wr_in && bank_sel_in == `ECTMR_BANK;
    assign rsel = rd_in && !wr_in && bank_sel_in == `ECTMR_BANK;
    // run shadow ignores the single-pass auto-clear, so it is only trusted when low
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctl_r <= 8'h00;
        end else if (hit && addr_in == `ECTMR_OFF_CONTROL) begin
            ctl_r <= wdata_in;
        end
    end
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_r <= 8'h00;
            high_r <= 8'h00;
        end else if (hit) begin
            if (addr_in == `ECTMR_OFF_LOW_HOLD) low_r <= wdata_in;
            if (addr_in == `ECTMR_OFF_HIGH_HOLD) high_r <= wdata_in;
        end
    end
    // ==========================================
    // properties
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_pin_port: assert property (!ctl_r[0] |-> counter_out_pin_out == port_data_in)
        else $error("pin not following port data");
    a_capture_gate: assert property (
        capture_irq_out == $past(capture_event_in & ctl_r[2]))
        else $error("capture interrupt mismatch");
    a_timeout_gate: assert property (timeout_irq_out |-> $past(ctl_r[1]))
        else $error("timeout interrupt while masked");
    a_unmapped_zero: assert property (rd_in && (bank_sel_in != `ECTMR_BANK
        || !(addr_in inside {4'h0, 4'h4, 4'h5})) |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_low_readback: assert property (rsel && addr_in == 4'h4 |=> rdata_out == low_r)
        else $error("low hold readback wrong");
    a_high_readback: assert property (rsel && addr_in == 4'h5 |=> rdata_out == high_r)
        else $error("high hold readback wrong");
    a_stopped_hold: assert property (
        !ctl_r[7] ##1 !ctl_r[7] |-> $stable(byte_counter_out))
        else $error("counter moved while stopped");
    a_irq_single: assert property (timeout_irq_out |=> !timeout_irq_out)
        else $error("timeout interrupt longer than one cycle");
    c_routed_tc: cover property (timeout_irq_out && ctl_r[0]);
    c_capture: cover property (capture_irq_out);
    c_high_read: cover property (rsel && addr_in == 4'h5);
endmodule
bind ectmr_top ectmr_asserts #(.COUNT_WIDTH(COUNT_WIDTH)) asrt_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .bank_sel_in(bank_sel_in), .addr_in(addr_in),
    .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .port_data_in(port_data_in), .capture_event_in(capture_event_in),
    .counter_out_pin_out(counter_out_pin_out), .timeout_irq_out(timeout_irq_out),
    .capture_irq_out(capture_irq_out), .byte_counter_out(byte_counter_out));

// File: tb/ectmr_top_tb.sv
// self-checking testbench for the eight-bit counter/timer
`timescale 1ns/1ps
module ectmr_top_tb;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [3:0] bank_sel_in = 4'hD;
    logic [3:0] addr_in = 4'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] wdata_in = 8'h00;
    logic port_data_in = 1'b0;
    logic capture_event_in = 1'b0;
    logic [7:0] rdata_out;
    logic pin;
    logic to_irq;
    logic cap_irq;
    logic [7:0] cnt;
    logic p;
    int bad_count = 0;
    int checked = 0;
    int n;
    ectmr_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .bank_sel_in(bank_sel_in),
        .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
        .rdata_out(rdata_out), .port_data_in(port_data_in),
        .capture_event_in(capture_event_in), .counter_out_pin_out(pin),
        .timeout_irq_out(to_irq), .capture_irq_out(cap_irq), .byte_counter_out(cnt));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    // ==========================================
    // access and compare tasks
    task automatic end_sim;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        checked++;
        if (got != exp) begin
            bad_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_in = a;
        wdata_in = d;
        wr_in = 1'b1;
        @(negedge clk_in);
        wr_in = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(negedge clk_in);
        addr_in = a;
        rd_in = 1'b1;
        @(negedge clk_in);
        rd_in = 1'b0;
        @(negedge clk_in);
        chk8(rdata_out, e);
    endtask
    // cycles up to the next timeout pulse; a hang ends the run
    task automatic wait_irq(output int c);
        c = 0;
        do begin
            @(negedge clk_in);
            c++;
        end while (to_irq !== 1'b1 && c < 400);
        if (c >= 400) begin
            bad_count++;
            end_sim();
        end
    endtask
    task automatic quiet(input int cyc);
        n = 0;
        repeat (cyc) begin
            @(negedge clk_in);
            if (to_irq !== 1'b0) n++;
        end
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(negedge clk_in);
        rstn_in = 1'b1;
        rd(4'h0, 8'h00);
        rd(4'h5, 8'h00);
        port_data_in = 1'b1;
        rd(4'h4, 8'h00);
        chk8({7'h00, pin}, 8'h01);
        $display("test reset done");
        wr(4'h4, 8'hA5);
        wr(4'h5, 8'h5A);
        rd(4'h4, 8'hA5);
        rd(4'h5, 8'h5A);
        rd(4'h2, 8'h00);
        bank_sel_in = 4'hE;
        wr(4'h4, 8'h11);
        bank_sel_in = 4'hD;
        rd(4'h4, 8'hA5);
        $display("test map done");
        wr(4'h4, 8'h04);
        for (int d = 0; d < 4; d++) begin
            wr(4'h0, 8'h20);
            wr(4'h0, 8'h82 | {3'b000, d[1:0], 3'b000});
            wait_irq(n); // first period may be short
            wait_irq(n);
            wait_irq(n);
            chkn(n, 5 << d);
        end
        wr(4'h0, 8'h02);
        rd(4'h0, 8'h22);
        wr(4'h0, 8'h22);
        rd(4'h0, 8'h02);
        wr(4'h0, 8'h80);
        quiet(30);
        chkn(n, 0);
        rd(4'h0, 8'hA0);
        $display("test modulo done");
        wr(4'h0, 8'h20);
        wr(4'h0, 8'hC2);
        wait_irq(n);
        quiet(20);
        chkn(n, 0);
        chk8(cnt, 8'h00);
        rd(4'h0, 8'h62);
        $display("test single done");
        wr(4'h4, 8'h03);
        wr(4'h5, 8'h06);
        wr(4'h0, 8'h20);
        wr(4'h0, 8'h83);
        wait_irq(n);
        p = pin;
        wait_irq(n);
        chkn(n, 7);
        chk8({7'h00, pin}, {7'h00, ~p});
        wait_irq(n);
        chkn(n, 4);
        $display("test route done");
        // reset in mid-count must bring the counter, control and high hold back to zero
        rstn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        chk8(cnt, 8'h00);
        chk8({7'h00, pin}, 8'h01);
        rstn_in = 1'b1;
        rd(4'h0, 8'h00);
        rd(4'h5, 8'h00);
        $display("test reset in run done");
        for (int m = 0; m < 2; m++) begin
            wr(4'h0, m == 0 ? 8'h04 : 8'h00);
            @(negedge clk_in);
            capture_event_in = 1'b1;
            @(negedge clk_in);
            capture_event_in = 1'b0;
            chk8({7'h00, cap_irq}, m == 0 ? 8'h01 : 8'h00);
        end
        $display("test capture done");
        end_sim();
    end
endmodule
